/* ncpb_bank.v */
/*
 nco preset bank: channel a presets 2-3, channel b presets 0-1.
 assumes the serial control port decodes frames into single-cycle
 read and write strobes with a 12-bit byte address, on clk.
*/
`timescale 1ns/1ps
`include "ncpb_map.vh"
module ncpb_bank (
    input wire clk,
    input wire rstn,
    input wire wr_en,
    input wire rd_en,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire interleave_mode,
    input wire [1:0] preset_sel,
    output reg [31:0] rdata_reg,
    output reg rvalid_reg,
    output reg addr_hit_reg,
    output reg [31:0] chan_a_freq_reg,
    output reg [31:0] chan_a_phase_reg,
    output reg [31:0] chan_b_freq_reg,
    output reg [31:0] chan_b_phase_reg
);
    wire [31:0] chan_a_freq_preset2;
    wire [31:0] chan_a_freq_preset3;
    wire [31:0] chan_b_freq_preset0;
    wire [31:0] chan_b_freq_preset1;
    wire [15:0] chan_a_phase_preset2;
    wire [15:0] chan_a_phase_preset3;
    wire [15:0] chan_b_phase_preset0;
    wire [15:0] chan_b_phase_preset1;

    ncpb_preg #(
        .W(32),
        .OFFSET(`NCPB_OFF_A_FREQ2),
        .RST(`NCPB_FREQ_RST)
    ) u_af2 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_a_freq_preset2)
    );

    ncpb_preg #(
        .W(32),
        .OFFSET(`NCPB_OFF_A_FREQ3),
        .RST(`NCPB_FREQ_RST)
    ) u_af3 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_a_freq_preset3)
    );

    // phase registers keep only wdata[15:0]; upper write bits are dropped
    ncpb_preg #(
        .W(16),
        .OFFSET(`NCPB_OFF_A_PHASE2),
        .RST({16'h0000, `NCPB_PHASE_RST})
    ) u_ap2 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_a_phase_preset2)
    );

    ncpb_preg #(
        .W(16),
        .OFFSET(`NCPB_OFF_A_PHASE3),
        .RST({16'h0000, `NCPB_PHASE_RST})
    ) u_ap3 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_a_phase_preset3)
    );

    // channel b registers stay readable and writable in interleaved mode
    ncpb_preg #(
        .W(32),
        .OFFSET(`NCPB_OFF_B_FREQ0),
        .RST(`NCPB_FREQ_RST)
    ) u_bf0 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_b_freq_preset0)
    );

    ncpb_preg #(
        .W(32),
        .OFFSET(`NCPB_OFF_B_FREQ1),
        .RST(`NCPB_FREQ_RST)
    ) u_bf1 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_b_freq_preset1)
    );

    ncpb_preg #(
        .W(16),
        .OFFSET(`NCPB_OFF_B_PHASE0),
        .RST({16'h0000, `NCPB_PHASE_RST})
    ) u_bp0 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_b_phase_preset0)
    );

    ncpb_preg #(
        .W(16),
        .OFFSET(`NCPB_OFF_B_PHASE1),
        .RST({16'h0000, `NCPB_PHASE_RST})
    ) u_bp1 (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .value_reg(chan_b_phase_preset1)
    );

    reg [31:0] rdata_next;
    reg hit_next;
    reg [31:0] a_freq_next;
    reg [15:0] a_phase_next;
    reg [31:0] b_freq_next;
    reg [15:0] b_phase_next;

    // read mux; phase words sit in the low half, upper bits read zero
    always @* begin
        rdata_next = 32'h0000_0000;
        hit_next = 1'b1;
        case (addr)
            `NCPB_OFF_A_FREQ2: rdata_next = chan_a_freq_preset2;
            `NCPB_OFF_A_FREQ3: rdata_next = chan_a_freq_preset3;
            `NCPB_OFF_A_PHASE2: rdata_next = {16'h0000, chan_a_phase_preset2};
            `NCPB_OFF_A_PHASE3: rdata_next = {16'h0000, chan_a_phase_preset3};
            `NCPB_OFF_B_FREQ0: rdata_next = chan_b_freq_preset0;
            `NCPB_OFF_B_FREQ1: rdata_next = chan_b_freq_preset1;
            `NCPB_OFF_B_PHASE0: rdata_next = {16'h0000, chan_b_phase_preset0};
            `NCPB_OFF_B_PHASE1: rdata_next = {16'h0000, chan_b_phase_preset1};
            default: hit_next = 1'b0;
        endcase
    end

    // presets 0-1 of a and 2-3 of b live elsewhere; those selections give
    // the reset tuning value here so the outputs never float undefined
    always @* begin
        a_freq_next = `NCPB_FREQ_RST;
        a_phase_next = `NCPB_PHASE_RST;
        b_freq_next = `NCPB_FREQ_RST;
        b_phase_next = `NCPB_PHASE_RST;
        case (preset_sel)
            2'b10: begin
                a_freq_next = chan_a_freq_preset2;
                a_phase_next = chan_a_phase_preset2;
            end
            2'b11: begin
                a_freq_next = chan_a_freq_preset3;
                a_phase_next = chan_a_phase_preset3;
            end
            2'b00: begin
                b_freq_next = chan_b_freq_preset0;
                b_phase_next = chan_b_phase_preset0;
            end
            2'b01: begin
                b_freq_next = chan_b_freq_preset1;
                b_phase_next = chan_b_phase_preset1;
            end
            default: begin
                a_freq_next = `NCPB_FREQ_RST;
            end
        endcase
        // in interleaved mode both oscillators follow channel a
        if (interleave_mode) begin
            b_freq_next = a_freq_next;
            b_phase_next = a_phase_next;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
            addr_hit_reg <= 1'b0;
            chan_a_freq_reg <= `NCPB_FREQ_RST;
            chan_a_phase_reg <= 32'h0000_0000;
            chan_b_freq_reg <= `NCPB_FREQ_RST;
            chan_b_phase_reg <= 32'h0000_0000;
        end else begin
            rvalid_reg <= rd_en;
            if (rd_en) begin
                rdata_reg <= rdata_next;
                addr_hit_reg <= hit_next;
            end
            chan_a_freq_reg <= a_freq_next;
            chan_b_freq_reg <= b_freq_next;
            // left justified, ready to add to the accumulator
            chan_a_phase_reg <= {a_phase_next, 16'h0000};
            chan_b_phase_reg <= {b_phase_next, 16'h0000};
        end
    end
endmodule

/* ncpb_bank_asserts.sv */
/* port checker for ncpb_bank.
 assumes bind to ncpb_bank, single clock. */
`timescale 1ns/1ps
module ncpb_bank_asserts (
    input wire clk,
    input wire rstn,
    input wire wr_en,
    input wire rd_en,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire interleave_mode,
    input wire [31:0] rdata_reg,
    input wire rvalid_reg,
    input wire addr_hit_reg,
    input wire [31:0] chan_a_freq_reg,
    input wire [31:0] chan_a_phase_reg,
    input wire [31:0] chan_b_freq_reg,
    input wire [31:0] chan_b_phase_reg
);
    wire hit = addr >= 12'h230 && addr <= 12'h24c && addr[1:0] == 2'b00;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wr; wr_en && !rd_en && addr == 12'h238; endsequence
    sequence s_rd; rd_en && !wr_en && addr == 12'h238; endsequence
    a_rd_answer: assert property (rd_en |=> rvalid_reg) else $error("read unanswered");
    a_idle_hold: assert property (!rd_en |=> !rvalid_reg && $stable(rdata_reg))
        else $error("read port moved without strobe");
    a_map_hit: assert property (rd_en |=> addr_hit_reg == $past(hit)) else $error("bad hit");
    a_miss_zero: assert property (rd_en && !hit |=> rdata_reg == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_phase_pad: assert property (chan_a_phase_reg[15:0] == 16'h0000 &&
        chan_b_phase_reg[15:0] == 16'h0000) else $error("phase not left justified");
    a_il_freq: assert property (interleave_mode |=> chan_b_freq_reg == chan_a_freq_reg)
        else $error("b freq not from a");
    a_il_phase: assert property (interleave_mode |=> chan_b_phase_reg == chan_a_phase_reg)
        else $error("b phase not from a");
    a_wr_rd: assert property (s_wr ##1 s_rd |=> rdata_reg == $past(wdata, 2))
        else $error("readback differs");
endmodule
bind ncpb_bank ncpb_bank_asserts u_chk (.clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .interleave_mode(interleave_mode), .rdata_reg(rdata_reg),
    .rvalid_reg(rvalid_reg), .addr_hit_reg(addr_hit_reg), .chan_a_freq_reg(chan_a_freq_reg),
    .chan_a_phase_reg(chan_a_phase_reg), .chan_b_freq_reg(chan_b_freq_reg),
    .chan_b_phase_reg(chan_b_phase_reg));

/* ncpb_bank_tb.sv */
/* self-checking bench for ncpb_bank.
 assumes the checker file is compiled alongside. */
`timescale 1ns/1ps
module ncpb_bank_tb;
    reg clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, il = 1'b0;
    reg [1:0] sel = 2'b00;
    reg [11:0] addr = 12'h000;
    reg [31:0] wdata = 32'h0000_0000;
    wire [31:0] rdata, af, ap, bf, bp;
    wire rvalid, hit;
    integer n_fail = 0, n_compared = 0, cyc = 0, i;
    ncpb_bank dut (.clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .interleave_mode(il), .preset_sel(sel), .rdata_reg(rdata),
        .rvalid_reg(rvalid), .addr_hit_reg(hit), .chan_a_freq_reg(af),
        .chan_a_phase_reg(ap), .chan_b_freq_reg(bf), .chan_b_phase_reg(bp));
    always #50 clk = ~clk;
    function [31:0] pat(input integer k);
        pat = 32'h8765_4321 + k * 32'h0101_0101;
    endfunction
    task results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task ck(input [31:0] g, input [31:0] e);
        n_compared = n_compared + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    // read strobe stays up until the next call, so back-to-back reads are legal
    task acc(input w, input r, input [11:0] a, input [31:0] d, input h);
        wr_en = w;
        rd_en = r;
        addr = a;
        wdata = d;
        @(negedge clk);
        if (r) begin
            ck(rdata, d);
            ck({30'h0, rvalid, hit}, {30'h0, 1'b1, h});
        end
    endtask
    task osc(input [1:0] s, input m, input [31:0] e0, e1, e2, e3);
        sel = s;
        il = m;
        repeat (2) @(negedge clk);
        ck(af, e0);
        ck(ap, e1);
        ck(bf, e2);
        ck(bp, e3);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 400) begin
            n_fail = n_fail + 1;
            results;
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        for (i = 0; i < 8; i = i + 1)
            acc(0, 1, 12'(12'h230 + 4 * i), i[0] ? 32'h0 : 32'hc000_0000, 1);
        for (i = 0; i < 8; i = i + 1)
            acc(1, 0, 12'(12'h230 + 4 * i), pat(i), 0);
        for (i = 0; i < 8; i = i + 1)
            acc(0, 1, 12'(12'h230 + 4 * i), i[0] ? pat(i) & 32'hffff : pat(i), 1);
        acc(1, 0, 12'h228, 32'h0000_1111, 0);
        acc(0, 1, 12'h228, 32'h0000_0000, 0);
        acc(0, 1, 12'h230, pat(0), 1);
        acc(0, 0, 12'h000, 32'h0, 0);
        osc(2'd2, 0, pat(0), pat(1) << 16, 32'hc000_0000, 32'h0);
        osc(2'd0, 0, 32'hc000_0000, 32'h0, pat(4), pat(5) << 16);
        osc(2'd1, 0, 32'hc000_0000, 32'h0, pat(6), pat(7) << 16);
        osc(2'd3, 1, pat(2), pat(3) << 16, pat(2), pat(3) << 16);
        osc(2'd1, 1, 32'hc000_0000, 32'h0, 32'hc000_0000, 32'h0);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        acc(0, 1, 12'h238, 32'hc000_0000, 1);
        acc(1, 0, 12'h238, 32'h5a5a_0f0f, 0);
        acc(0, 1, 12'h238, 32'h5a5a_0f0f, 1);
        acc(0, 0, 12'h000, 32'h0, 0);
        results;
    end
endmodule

/* ncpb_map.vh */
/*
 nco preset register bank: offsets, field widths, reset values.
 assumes inclusion by ncpb_bank.v and the verification side.
*/
`ifndef NCPB_MAP_VH
`define NCPB_MAP_VH

`define NCPB_ADDR_W 12
`define NCPB_FREQ_W 32
`define NCPB_PHASE_W 16
`define NCPB_ACC_W 32

`define NCPB_OFF_A_FREQ2 12'h0230
`define NCPB_OFF_A_PHASE2 12'h0234
`define NCPB_OFF_A_FREQ3 12'h0238
`define NCPB_OFF_A_PHASE3 12'h023c
`define NCPB_OFF_B_FREQ0 12'h0240
`define NCPB_OFF_B_PHASE0 12'h0244
`define NCPB_OFF_B_FREQ1 12'h0248
`define NCPB_OFF_B_PHASE1 12'h024c

`define NCPB_FREQ_RST 32'hc000_0000
`define NCPB_PHASE_RST 16'h0000

`endif

/* ncpb_preg.v */
/*
 one read-write preset register with its own decode.
 assumes a single-cycle write strobe on the register clock.
*/
`timescale 1ns/1ps
module ncpb_preg #(
    parameter W = 32,
    parameter [11:0] OFFSET = 12'h0000,
    parameter [31:0] RST = 32'h0000_0000
) (
    input wire clk,
    input wire rstn,
    input wire wr_en,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    output reg [W-1:0] value_reg
);
    wire hit;
    assign hit = (addr == OFFSET);

    always @(posedge clk) begin
        if (!rstn) begin
            value_reg <= RST[W-1:0];
        end else if (wr_en && hit) begin
            value_reg <= wdata[W-1:0];
        end
    end
endmodule
